// ---- async_serial_tx_pkg.sv ----
// constants, register map and types for the asynchronous serial transmitter
// Functional notes
// - frame: low start, 8/9 data, high stop
// - line idles at mark level
// - every bit lasts one baud period
// - least significant bit sent first
// - no hardware parity; software fills ninth bit
// - sends only when enabled, async, port on
// - port enable turns shared pin to output only while also enabled and async
// - disabled transmitter releases the pin
// - buffer write starts send, immediate if idle
// - queued character follows stop bit at once
// - polarity bit inverts whole line waveform
// - empty flag set while enabled, unless busy and queued
// - empty flag settles two cycles after write
// - empty flag cannot be written by software
// - enabling transmitter sets empty flag
// - interrupt when flag and all enables set
// - shifter empty status clears during character
// - nine-bit mode sends ninth bit last
// - bit timing from 8/16-bit divisor generator
`default_nettype none
package async_serial_tx_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DIV = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0c;
	localparam logic [7:0] OFS_IRQ = 8'h10;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [15:0] DIV_RST = 16'h0000;
	localparam logic [2:0] IRQ_RST = 3'h0;
	// bit timer width: 65536 divisor steps times 64 clocks
	localparam int PER_W = 23;
	localparam logic [3:0] BITS_8 = 4'h8;
	localparam logic [3:0] BITS_9 = 4'h9;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// control register, bit 7 down to bit 0
	typedef struct packed {
		logic ninth_data;
		logic wide_select;
		logic high_speed;
		logic polarity_invert;
		logic nine_bit;
		logic port_enable;
		logic clocked_mode;
		logic tx_enable;
	} ctrl_t;
	// interrupt enables, bit 2 down to bit 0
	typedef struct packed {
		logic peripheral_irq_enable;
		logic global_irq_enable;
		logic tx_empty_irq_enable;
	} irq_en_t;
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} tx_state_t;
endpackage
`default_nettype wire

// ---- async_serial_transmitter.sv ----
// asynchronous serial transmitter with holding buffer and axi4-lite registers
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`default_nettype none
module async_serial_transmitter (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// axi4-lite write channels
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	// axi4-lite read channels
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [31:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	// serial pin and interrupt
	output logic o_tx,
	output logic o_tx_oe,
	output logic o_irq
);
	import async_serial_tx_pkg::*;

	// bit period in clocks minus one, from divisor and rate selects
	function automatic logic [PER_W-1:0] period_m1(input logic [15:0] dv,
			input logic wide, input logic high);
		logic [PER_W-1:0] steps;
		steps = wide ? {7'h00, dv} + 23'h000001 : {15'h0000, dv[7:0]} + 23'h000001;
		if (wide && high)
			period_m1 = (steps << 2) - 23'h000001;
		else if (wide || high)
			period_m1 = (steps << 4) - 23'h000001;
		else
			period_m1 = (steps << 6) - 23'h000001;
	endfunction

	ctrl_t ctrl_ff;
	irq_en_t irq_en_ff;
	logic [15:0] div_ff;
	logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0] wstrb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	tx_state_t state_ff, nxt_state;
	logic [PER_W-1:0] tmr_ff, nxt_tmr;
	logic [8:0] shift_ff, nxt_shift;
	logic [3:0] bits_ff, nxt_bits;
	logic hold_valid_ff, nxt_hold_valid;
	logic [8:0] hold_data_ff;
	logic flag_ff, nxt_flag;
	logic tx_ff, nxt_tx, oe_ff;

	// write path: address and data are taken in either order
	wire do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
	wire aw_take = i_awvalid && o_awready;
	wire w_take = i_wvalid && o_wready;
	wire wr_ctrl = do_write && awaddr_ff == OFS_CTRL;
	wire wr_div = do_write && awaddr_ff == OFS_DIV;
	wire wr_data = do_write && awaddr_ff == OFS_DATA;
	wire wr_stat = do_write && awaddr_ff == OFS_STAT;
	wire wr_irq = do_write && awaddr_ff == OFS_IRQ;
	wire wr_hit = wr_ctrl || wr_div || wr_data || wr_stat || wr_irq;
	assign o_awready = !aw_hold_ff && !bvalid_ff;
	assign o_wready = !w_hold_ff && !bvalid_ff;
	assign o_bvalid = bvalid_ff;
	assign o_bresp = bresp_ff;

	// read path: one cycle from address to data
	wire ar_take = i_arvalid && o_arready;
	wire [7:0] ra = i_araddr[7:0];
	wire ra_hi_zero = i_araddr[31:8] == 24'h000000;
	wire rd_hit = ra_hi_zero && (ra == OFS_CTRL || ra == OFS_DIV || ra == OFS_DATA
		|| ra == OFS_STAT || ra == OFS_IRQ);
	wire [1:0] stat_word = {state_ff == ST_IDLE, flag_ff};
	wire [31:0] rd_word = !ra_hi_zero ? 32'h00000000 :
		ra == OFS_CTRL ? {24'h000000, ctrl_ff} :
		ra == OFS_DIV ? {16'h0000, div_ff} :
		ra == OFS_STAT ? {30'h00000000, stat_word} :
		ra == OFS_IRQ ? {29'h00000000, irq_en_ff} : 32'h00000000;
	assign o_arready = !rvalid_ff;
	assign o_rvalid = rvalid_ff;
	assign o_rdata = rdata_ff;
	assign o_rresp = rresp_ff;

	// bus channel state
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			rvalid_ff <= 1'b0;
			rresp_ff <= RESP_OKAY;
		end else begin
			aw_hold_ff <= aw_take || (aw_hold_ff && !do_write);
			w_hold_ff <= w_take || (w_hold_ff && !do_write);
			bvalid_ff <= do_write || (bvalid_ff && !i_bready);
			if (do_write)
				bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			rvalid_ff <= ar_take || (rvalid_ff && !i_rready);
			if (ar_take)
				rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// captured bus payloads carry no reset; they are read only when held
	always_ff @(posedge i_clk) begin
		if (aw_take)
			awaddr_ff <= (i_awaddr[31:8] == 24'h000000) ? i_awaddr[7:0] : 8'hff;
		if (w_take) begin
			wdata_ff <= i_wdata;
			wstrb_ff <= i_wstrb;
		end
		if (ar_take)
			rdata_ff <= rd_word;
	end

	// software registers; the status word has no write path at all
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ctrl_ff <= ctrl_t'(CTRL_RST);
			div_ff <= DIV_RST;
			irq_en_ff <= irq_en_t'(IRQ_RST);
		end else begin
			if (wr_ctrl && wstrb_ff[0])
				ctrl_ff <= ctrl_t'(wdata_ff[7:0]);
			if (wr_div && wstrb_ff[0])
				div_ff[7:0] <= wdata_ff[7:0];
			if (wr_div && wstrb_ff[1])
				div_ff[15:8] <= wdata_ff[15:8];
			if (wr_irq && wstrb_ff[0])
				irq_en_ff <= irq_en_t'(wdata_ff[2:0]);
		end
	end

	// transmitter runs only in the async, port-enabled, enabled setting
	wire active = ctrl_ff.tx_enable && !ctrl_ff.clocked_mode && ctrl_ff.port_enable;
	wire [PER_W-1:0] per_m1 = period_m1(div_ff, ctrl_ff.wide_select,
		ctrl_ff.high_speed);
	wire bit_end = tmr_ff == per_m1;
	wire data_wr = wr_data && wstrb_ff[0] && active;
	// the queued character moves in from idle, or straight after the stop bit
	wire load_now = active && hold_valid_ff &&
		(state_ff == ST_IDLE || (state_ff == ST_STOP && bit_end));
	wire [3:0] char_bits = ctrl_ff.nine_bit ? BITS_9 : BITS_8;

	// holding buffer: one deep, captures the ninth bit with the data
	assign nxt_hold_valid = active && (data_wr || (hold_valid_ff && !load_now));
	// flag looks past a same-cycle transfer so an idle load does not blink it
	assign nxt_flag = ctrl_ff.tx_enable && !(hold_valid_ff && !load_now);

	// frame sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_tmr = bit_end ? {PER_W{1'b0}} : tmr_ff + 23'h000001;
		nxt_shift = shift_ff;
		nxt_bits = bits_ff;
		if (!active) begin
			nxt_state = ST_IDLE;
			nxt_tmr = {PER_W{1'b0}};
		end else if (load_now) begin
			nxt_state = ST_START;
			nxt_tmr = {PER_W{1'b0}};
			nxt_shift = hold_data_ff;
			nxt_bits = char_bits;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					nxt_tmr = {PER_W{1'b0}};
				end
				ST_START: begin
					if (bit_end)
						nxt_state = ST_DATA;
				end
				ST_DATA: begin
					if (bit_end) begin
						nxt_shift = {1'b0, shift_ff[8:1]};
						nxt_bits = bits_ff - 4'h1;
						if (bits_ff == 4'h1)
							nxt_state = ST_STOP;
					end
				end
				ST_STOP: begin
					if (bit_end)
						nxt_state = ST_IDLE;
				end
				default: begin
					nxt_state = ST_IDLE;
				end
			endcase
		end
	end

	// line level before polarity; no parity stage exists in the path
	always_comb begin
		case (nxt_state)
			ST_START: nxt_tx = 1'b0;
			ST_DATA: nxt_tx = nxt_shift[0];
			default: nxt_tx = 1'b1;
		endcase
	end

	// sequencer and buffer registers
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_ff <= ST_IDLE;
			tmr_ff <= {PER_W{1'b0}};
			shift_ff <= 9'h000;
			bits_ff <= 4'h0;
			hold_valid_ff <= 1'b0;
			hold_data_ff <= 9'h000;
			flag_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			tmr_ff <= nxt_tmr;
			shift_ff <= nxt_shift;
			bits_ff <= nxt_bits;
			hold_valid_ff <= nxt_hold_valid;
			if (data_wr)
				hold_data_ff <= {ctrl_ff.ninth_data, wdata_ff[7:0]};
			flag_ff <= nxt_flag;
		end
	end

	// pin drive: inversion covers idle too, so an inverted line idles low
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			tx_ff <= 1'b1;
			oe_ff <= 1'b0;
		end else begin
			tx_ff <= nxt_tx ^ ctrl_ff.polarity_invert;
			oe_ff <= active;
		end
	end
	assign o_tx = tx_ff;
	assign o_tx_oe = oe_ff;
	// request needs the flag and all three enables; no extra latency
	assign o_irq = flag_ff && irq_en_ff.tx_empty_irq_enable &&
		irq_en_ff.global_irq_enable && irq_en_ff.peripheral_irq_enable;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	// mark is a one before polarity, so the pin shows the inverse of the invert bit
	idle_mark_a: assert property (state_ff == ST_IDLE && active && !load_now |=>
		o_tx == !$past(ctrl_ff.polarity_invert)) else $error("idle line not at mark");
	// a space is a zero before polarity, so the pin shows the invert bit itself
	start_space_a: assert property (load_now |=>
		state_ff == ST_START ##0 o_tx == $past(ctrl_ff.polarity_invert))
		else $error("start bit missing");
	bit_length_a: assert property ($fell(state_ff == ST_START) && active |->
		$past(tmr_ff) == $past(per_m1)) else $error("start bit length wrong");
	lsb_first_a: assert property (state_ff == ST_START && bit_end && active |=>
		o_tx == ($past(shift_ff[0]) ^ $past(ctrl_ff.polarity_invert)))
		else $error("first data bit not lsb");
	stop_one_a: assert property (state_ff == ST_STOP && bit_end && active &&
		!hold_valid_ff |=> state_ff == ST_IDLE) else $error("stop not single");
	queued_follow_a: assert property (state_ff == ST_STOP && bit_end && active &&
		hold_valid_ff |=> state_ff == ST_START) else $error("queued char late");
	// only start and data states: the stop bit could hand over the queued word early
	flag_delay_a: assert property (data_wr && !hold_valid_ff &&
		(state_ff == ST_START || state_ff == ST_DATA) |=> flag_ff ##1 !flag_ff)
		else $error("empty flag timing wrong");
	shifter_busy_a: assert property (load_now |=>
		stat_word[1] == 1'b0) else $error("shifter status not cleared");
	pin_enable_a: assert property (##1 o_tx_oe == $past(active))
		else $error("pin direction wrong");
	enable_flag_a: assert property ($rose(ctrl_ff.tx_enable) && !hold_valid_ff |=>
		flag_ff) else $error("enable did not set flag");

	// a clear flag while running means a word really waits in the buffer
	flag_busy_a: assert property (!flag_ff && $past(active) |->
		hold_valid_ff) else $error("empty flag clear with empty buffer");

	// an empty buffer with the transmitter on must show the flag set
	flag_set_a: assert property (ctrl_ff.tx_enable && !hold_valid_ff |=>
		flag_ff) else $error("empty flag not set");

	// nine-bit mode loads a nine-bit count into the shifter
	ninth_bit_a: assert property (load_now && ctrl_ff.nine_bit |=>
		bits_ff == BITS_9) else $error("ninth bit not counted");

	// an inactive transmitter parks the pin at mark in the chosen polarity
	inactive_line_a: assert property (!active |=>
		o_tx == !$past(ctrl_ff.polarity_invert)) else $error("inactive line not at mark");

	// dropping any enable aborts the frame and empties the buffer
	inactive_idle_a: assert property (!active |=>
		state_ff == ST_IDLE && !hold_valid_ff) else $error("inactive but still busy");

	// every later data bit is the next bit up of the shifter
	data_shift_a: assert property (state_ff == ST_DATA && bit_end && active &&
		bits_ff != 4'h1 |=> o_tx == ($past(shift_ff[1]) ^ $past(ctrl_ff.polarity_invert)))
		else $error("data bits out of order");

	// the last data bit is followed by a mark-level stop bit
	stop_mark_a: assert property (state_ff == ST_DATA && bit_end && active &&
		bits_ff == 4'h1 |=> o_tx == !$past(ctrl_ff.polarity_invert))
		else $error("stop bit not at mark");

	// an idle shifter picks up a new word one cycle after it lands in the buffer
	idle_load_a: assert property (data_wr && state_ff == ST_IDLE &&
		!hold_valid_ff |=> ##1 state_ff == ST_START) else $error("idle load late");

	// no request can stand without the flag behind it
	irq_gate_a: assert property (!flag_ff |->
		!o_irq) else $error("request without empty flag");

	back_to_back_c: cover property (state_ff == ST_STOP && bit_end && load_now);
	nine_bit_c: cover property (load_now && ctrl_ff.nine_bit);
	inverted_c: cover property (state_ff == ST_DATA && ctrl_ff.polarity_invert);
	irq_c: cover property ($rose(o_irq));
	nine_stop_c: cover property (state_ff == ST_STOP && ctrl_ff.nine_bit);
endmodule
`default_nettype wire

// ---- serial_line_receiver.sv ----
// remote serial receiver model that decodes frames seen on the transmit pin
`default_nettype none
module serial_line_receiver #(
	parameter int P = 8
) (
	// clock and line
	input wire logic i_clk,
	input wire logic i_line,
	// format shared with the transmitter
	input wire logic i_inv,
	input wire logic i_nine,
	// decoded results
	output logic [8:0] o_char,
	output logic [31:0] o_count,
	output logic [31:0] o_gap,
	output logic [31:0] o_ferr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] now_ff = 32'h0;
	logic [31:0] last;
	logic [8:0] ch;
	logic lvl;
	// undo the polarity so that marks read as one
	assign lvl = i_line ^ i_inv;
	// sampling on the falling edge keeps clear of the line's own updates
	always @(negedge i_clk) begin
		now_ff <= now_ff + 32'h1;
	end
	// hunt for a space, then sample each bit in its middle
	initial begin
		o_count = 0;
		o_ferr = 0;
		o_gap = 0;
		o_char = 9'h0;
		last = 0;
		forever begin
			@(negedge i_clk);
			if (lvl === 1'b0) begin
				o_gap = now_ff - last; // start to start spacing
				last = now_ff;
				repeat (P / 2) @(negedge i_clk);
				if (lvl !== 1'b0) o_ferr = o_ferr + 1; // start bit is a space
				ch = 9'h0;
				for (int k = 0; k < (i_nine ? 9 : 8); k++) begin
					repeat (P) @(negedge i_clk);
					ch[k] = lvl; // first data bit is the least significant
				end
				repeat (P) @(negedge i_clk);
				if (lvl !== 1'b1) o_ferr = o_ferr + 1; // stop bit is a mark
				o_char = ch;
				o_count = o_count + 1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- test_async_serial_transmitter.sv ----
// self-checking bench for the asynchronous serial transmitter
`default_nettype none
module test_async_serial_transmitter;
	import async_serial_tx_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int P = 8; // wide and high speed with divisor 1: 2 steps of 4 clocks
	logic i_clk, i_reset, awvalid, wvalid, bready, arvalid, rready, inv, nine;
	logic [31:0] awaddr, wdata, araddr, rdata, rx_count, rx_gap, rx_ferr;
	logic [31:0] mismatches, checked, cycles;
	logic [1:0] resp;
	logic [8:0] rx_char;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_tx, o_tx_oe, o_irq;
	logic [1:0] o_bresp, o_rresp;
	logic [31:0] o_rdata;
	async_serial_transmitter async_serial_transmitter_i (.i_clk(i_clk), .i_reset(i_reset),
		.i_awvalid(awvalid), .o_awready(o_awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
		.o_wready(o_wready), .i_wdata(wdata), .i_wstrb(4'hf), .o_bvalid(o_bvalid),
		.i_bready(bready), .o_bresp(o_bresp), .i_arvalid(arvalid), .o_arready(o_arready),
		.i_araddr(araddr), .o_rvalid(o_rvalid), .i_rready(rready), .o_rdata(o_rdata),
		.o_rresp(o_rresp), .o_tx(o_tx), .o_tx_oe(o_tx_oe), .o_irq(o_irq));
	serial_line_receiver #(.P(P)) serial_line_receiver_i (.i_clk(i_clk), .i_line(o_tx),
		.i_inv(inv), .i_nine(nine), .o_char(rx_char), .o_count(rx_count), .o_gap(rx_gap),
		.o_ferr(rx_ferr));
	// free running clock
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	task automatic close_out();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checked = checked + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic sa, sw, sb;
		@(posedge i_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge i_clk);
			sa = awvalid && o_awready;
			sw = wvalid && o_wready;
			sb = o_bvalid;
			resp = o_bresp;
			@(posedge i_clk);
			if (sa) awvalid <= 1'b0;
			if (sw) wvalid <= 1'b0;
		end while (!sb);
		bready <= 1'b0;
		chk({30'h0, resp}, {30'h0, er}, "write response");
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic sa, sr;
		@(posedge i_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge i_clk);
			sa = arvalid && o_arready;
			sr = o_rvalid;
			rdata = o_rdata;
			resp = o_rresp;
			@(posedge i_clk);
			if (sa) arvalid <= 1'b0;
		end while (!sr);
		rready <= 1'b0;
		chk(rdata, ed, "read data");
		chk({30'h0, resp}, {30'h0, er}, "read response");
	endtask
	// hang guard: the whole sequence needs well under two thousand cycles
	always @(posedge i_clk) begin
		cycles <= cycles + 32'h1;
		if (cycles == 32'd20000) begin
			mismatches = mismatches + 1;
			close_out();
		end
	end
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, inv, nine} = 7'h0;
		{awaddr, wdata, araddr} = 96'h0;
		{mismatches, checked, cycles} = 96'h0;
		i_reset = 1'b1;
		repeat (3) @(posedge i_clk);
		i_reset <= 1'b0;
		@(negedge i_clk);
		chk({30'h0, o_tx, o_tx_oe}, 32'h2, "idle pin after reset");
		rd({24'h0, OFS_CTRL}, 32'h0, RESP_OKAY);
		rd({24'h0, OFS_STAT}, 32'h2, RESP_OKAY);
		// software order: rate, port and async, then enable
		wr({24'h0, OFS_DIV}, 32'h1, RESP_OKAY);
		rd({24'h0, OFS_DIV}, 32'h1, RESP_OKAY);
		wr({24'h0, OFS_CTRL}, 32'h64, RESP_OKAY);
		@(negedge i_clk);
		chk({31'h0, o_tx_oe}, 32'h0, "pin driven while disabled");
		wr({24'h0, OFS_CTRL}, 32'h65, RESP_OKAY);
		@(negedge i_clk);
		chk({30'h0, o_tx, o_tx_oe}, 32'h3, "pin not driven at mark");
		rd({24'h0, OFS_STAT}, 32'h3, RESP_OKAY);
		wr({24'h0, OFS_STAT}, 32'h0, RESP_OKAY);
		rd({24'h0, OFS_STAT}, 32'h3, RESP_OKAY);
		rd({24'h0, 8'h20}, 32'h0, RESP_SLVERR);
		// interrupt needs flag and all three enables
		wr({24'h0, OFS_IRQ}, 32'h7, RESP_OKAY);
		@(negedge i_clk);
		chk({31'h0, o_irq}, 32'h1, "irq with all enables");
		wr({24'h0, OFS_IRQ}, 32'h3, RESP_OKAY);
		@(negedge i_clk);
		chk({31'h0, o_irq}, 32'h0, "irq without peripheral enable");
		wr({24'h0, OFS_IRQ}, 32'h0, RESP_OKAY);
		rd({24'h0, OFS_STAT}, 32'h3, RESP_OKAY);
		// single character, then two back to back
		wr({24'h0, OFS_DATA}, 32'ha5, RESP_OKAY);
		rd({24'h0, OFS_STAT}, 32'h1, RESP_OKAY);
		wait (rx_count == 32'd1);
		chk({23'h0, rx_char}, 32'ha5, "first character");
		wr({24'h0, OFS_DATA}, 32'h3c, RESP_OKAY);
		wr({24'h0, OFS_DATA}, 32'hc3, RESP_OKAY);
		rd({24'h0, OFS_STAT}, 32'h0, RESP_OKAY);
		wait (rx_count == 32'd3);
		chk({23'h0, rx_char}, 32'hc3, "queued character");
		chk(rx_gap, 10 * P, "start to start spacing");
		repeat (P) @(negedge i_clk);
		rd({24'h0, OFS_STAT}, 32'h3, RESP_OKAY);
		// nine bits: ninth bit set before the data write
		nine = 1'b1;
		wr({24'h0, OFS_CTRL}, 32'hed, RESP_OKAY);
		wr({24'h0, OFS_DATA}, 32'h55, RESP_OKAY);
		wait (rx_count == 32'd4);
		chk({23'h0, rx_char}, 32'h155, "nine bit character");
		repeat (P) @(negedge i_clk);
		// inverted line, eight bits
		nine = 1'b0;
		// the pin flips at the edge this write returns on, so the model follows then
		wr({24'h0, OFS_CTRL}, 32'h75, RESP_OKAY);
		inv = 1'b1;
		@(negedge i_clk);
		chk({31'h0, o_tx}, 32'h0, "inverted idle");
		wr({24'h0, OFS_DATA}, 32'h81, RESP_OKAY);
		wait (rx_count == 32'd5);
		chk({23'h0, rx_char}, 32'h81, "inverted character");
		chk(rx_ferr, 32'h0, "framing faults");
		repeat (P) @(negedge i_clk);
		wr({24'h0, OFS_CTRL}, 32'h64, RESP_OKAY);
		@(negedge i_clk);
		chk({31'h0, o_tx_oe}, 32'h0, "pin released");
		rd({24'h0, OFS_STAT}, 32'h2, RESP_OKAY);
		close_out();
	end
endmodule
`default_nettype wire
